// file: src/fhb_cfg.svh
// fhb_cfg.svh: register offsets, field positions, reset values and sizes
// for the data link packet and code port; definitions only
`ifndef FHB_CFG_SVH
`define FHB_CFG_SVH
`define FHB_ADDR_RX_CODE 8'h04
`define FHB_ADDR_RX_DATA 8'h05
`define FHB_ADDR_TX_STAT 8'h06
`define FHB_ADDR_TX_CODE 8'h07
`define FHB_ADDR_TX_DATA 8'h08
`define FHB_ADDR_RX_STAT 8'h09
`define FHB_ADDR_IRQ_STAT 8'h0a
`define FHB_ADDR_IRQ_MASK 8'h0b
`define FHB_BIT_SEND 7
`define FHB_BIT_SEL 6
`define FHB_BIT_RX_SEEN 7
`define FHB_BIT_TX_EMPTY 2
`define FHB_BIT_TX_FULL 1
`define FHB_BIT_TX_UDR 0
`define FHB_BIT_RX_OVR 2
`define FHB_BIT_RX_LAST 1
`define FHB_BIT_RX_FIRST 0
`define FHB_RX_CODE_RST 6'h3f
`define FHB_DEPTH 64
`define FHB_PTR_W 6
`define FHB_CNT_W 7
`define FHB_CNT_FULL 7'h40
`define FHB_CNT_ZERO 7'h00
`define FHB_CNT_ONE 7'h01
`define FHB_BIT_LAST 3'h5
`define FHB_ABORT_LEN 3'h7
`define FHB_IRQ_UDR 0
`define FHB_IRQ_OVR 1
`define FHB_IRQ_CODE 2
`endif

// file: src/fhb_pkg.sv
// fhb_pkg: types shared by the data link packet and code port
// assumes fhb_cfg.svh is on the include path
package fhb_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fhb_bus_s;
  typedef struct packed {
    logic [7:0] data;
    logic first;
    logic last;
  } fhb_rx_byte_s;
  typedef enum logic [1:0] {
    FHB_IDLE,
    FHB_CODE,
    FHB_ABORT
  } fhb_tx_e;
endpackage

// file: src/fhb_port.sv
// fhb_port: host register port of the data link packet and code controller
// assumes one 40 MHz clock, synchronous inputs and a host bus that never waits
// Behaviour
// - the received-code flag stays set until the host reads the code register.
// - the six received code bits show the last validated code and reset to ones.
// - a read of the receive data port returns the next received byte, msb in bit 7.
// - the transmit-empty bit shows live that the transmit fifo holds nothing.
// - the transmit-full bit shows live that the transmit fifo is full.
// - a fifo that runs dry inside a packet makes the device send an abort and flag underrun.
// - the underrun flag stays set until the host reads the transmit status register.
// - code sending starts only on a zero to one change of the send bit.
// - the select bit picks the external link input at 0 and the controller at 1.
// - the six-bit code goes out bit 0 first and bit 5 last.
// - a write to the transmit data port queues one byte, msb in bit 7.
// - receive status flags whether the readable byte opens or closes a packet.
// - a receive overrun flag latches when a byte meets a full receive fifo.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "fhb_cfg.svh"
module fhb_port (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire fhb_pkg::fhb_bus_s bus_i,
  output logic [7:0] rdata_o,
  output logic irq_o,
  input wire logic rx_code_valid_i,
  input wire logic [5:0] rx_code_i,
  input wire logic rx_byte_valid_i,
  input wire fhb_pkg::fhb_rx_byte_s rx_byte_i,
  input wire logic tx_bit_req_i,
  input wire logic tx_in_packet_i,
  output logic [7:0] tx_byte_o,
  output logic tx_byte_valid_o,
  input wire logic external_link_data_in_i,
  output logic link_out_o
);
  import fhb_pkg::*;

  logic [7:0] rx_mem [0:`FHB_DEPTH-1];
  logic [7:0] tx_mem [0:`FHB_DEPTH-1];
  logic [1:0] rx_tag [0:`FHB_DEPTH-1];

  logic [5:0] rx_code_reg, rx_code_next;
  logic rx_seen_reg, rx_seen_next;
  logic [7:0] tx_ctl_reg, tx_ctl_next;
  logic send_prev_reg, send_prev_next;
  logic tx_udr_reg, tx_udr_next;
  logic rx_ovr_reg, rx_ovr_next;
  logic [2:0] irq_stat_reg, irq_stat_next;
  logic [2:0] irq_mask_reg, irq_mask_next;
  logic [7:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;
  logic [`FHB_PTR_W-1:0] rx_wp_reg, rx_wp_next, rx_rp_reg, rx_rp_next;
  logic [`FHB_CNT_W-1:0] rx_cnt_reg, rx_cnt_next;
  logic [`FHB_PTR_W-1:0] tx_wp_reg, tx_wp_next, tx_rp_reg, tx_rp_next;
  logic [`FHB_CNT_W-1:0] tx_cnt_reg, tx_cnt_next;
  fhb_tx_e tx_st_reg, tx_st_next;
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  logic link_reg, link_next;
  logic [7:0] tx_byte_reg, tx_byte_next;
  logic tx_bv_reg, tx_bv_next;

  logic wr_hit_tx, rd_rx, rx_push, rx_full, tx_push, tx_pop, tx_empty, tx_full;
  logic tx_udr_evt, rx_ovr_evt, code_evt, send_rise;

  function automatic logic hit(input fhb_bus_s b, input logic [7:0] a, input logic w);
    hit = (w ? b.wr : b.rd) && (b.addr == a);
  endfunction

  assign tx_empty = (tx_cnt_reg == `FHB_CNT_ZERO);
  assign tx_full = (tx_cnt_reg == `FHB_CNT_FULL);
  assign rx_full = (rx_cnt_reg == `FHB_CNT_FULL);
  assign wr_hit_tx = hit(bus_i, `FHB_ADDR_TX_DATA, 1'b1);
  assign tx_push = wr_hit_tx && !tx_full;
  assign rd_rx = hit(bus_i, `FHB_ADDR_RX_DATA, 1'b0) && (rx_cnt_reg != `FHB_CNT_ZERO);
  assign rx_push = rx_byte_valid_i && !rx_full;
  assign rx_ovr_evt = rx_byte_valid_i && rx_full;
  // a send edge owns the idle slot; a pop beside it would drop the byte unseen
  assign send_rise = tx_ctl_reg[`FHB_BIT_SEND] && !send_prev_reg;
  assign tx_pop = tx_bit_req_i && tx_ctl_reg[`FHB_BIT_SEL] && (tx_st_reg == FHB_IDLE)
    && !tx_empty && !send_rise;
  assign tx_udr_evt = tx_bit_req_i && tx_ctl_reg[`FHB_BIT_SEL] && (tx_st_reg == FHB_IDLE)
    && tx_empty && tx_in_packet_i && !send_rise;
  assign code_evt = rx_code_valid_i;

  // memories are written without reset; counts qualify the receive tags and transmit pops, but a receive data read returns memory even when empty
  always_ff @(posedge clk_i) begin
    if (rx_push) begin
      rx_mem[rx_wp_reg] <= rx_byte_i.data;
      rx_tag[rx_wp_reg] <= {rx_byte_i.last, rx_byte_i.first};
    end
    if (tx_push) begin
      tx_mem[tx_wp_reg] <= bus_i.wdata;
    end
  end

  always_comb begin
    rx_wp_next = rx_wp_reg + (rx_push ? 6'h01 : 6'h00);
    rx_rp_next = rx_rp_reg + (rd_rx ? 6'h01 : 6'h00);
    rx_cnt_next = rx_cnt_reg + (rx_push ? `FHB_CNT_ONE : `FHB_CNT_ZERO)
      - (rd_rx ? `FHB_CNT_ONE : `FHB_CNT_ZERO);
    tx_wp_next = tx_wp_reg + (tx_push ? 6'h01 : 6'h00);
    tx_rp_next = tx_rp_reg + (tx_pop ? 6'h01 : 6'h00);
    tx_cnt_next = tx_cnt_reg + (tx_push ? `FHB_CNT_ONE : `FHB_CNT_ZERO)
      - (tx_pop ? `FHB_CNT_ONE : `FHB_CNT_ZERO);
  end

  // register file; a hardware set beats the read or write that clears
  always_comb begin
    rx_code_next = rx_code_valid_i ? rx_code_i : rx_code_reg;
    rx_seen_next = rx_seen_reg;
    if (hit(bus_i, `FHB_ADDR_RX_CODE, 1'b0)) begin
      rx_seen_next = 1'b0;
    end
    if (code_evt) begin
      rx_seen_next = 1'b1;
    end
    tx_udr_next = tx_udr_reg;
    if (hit(bus_i, `FHB_ADDR_TX_STAT, 1'b0)) begin
      tx_udr_next = 1'b0;
    end
    if (tx_udr_evt) begin
      tx_udr_next = 1'b1;
    end
    rx_ovr_next = rx_ovr_reg;
    if (hit(bus_i, `FHB_ADDR_RX_STAT, 1'b0)) begin
      rx_ovr_next = 1'b0;
    end
    if (rx_ovr_evt) begin
      rx_ovr_next = 1'b1;
    end
    tx_ctl_next = tx_ctl_reg;
    if (hit(bus_i, `FHB_ADDR_TX_CODE, 1'b1)) begin
      tx_ctl_next = bus_i.wdata;
    end
    send_prev_next = tx_ctl_reg[`FHB_BIT_SEND];
    irq_mask_next = irq_mask_reg;
    if (hit(bus_i, `FHB_ADDR_IRQ_MASK, 1'b1)) begin
      irq_mask_next = bus_i.wdata[2:0];
    end
    irq_stat_next = irq_stat_reg;
    if (hit(bus_i, `FHB_ADDR_IRQ_STAT, 1'b1)) begin
      irq_stat_next = irq_stat_reg & ~bus_i.wdata[2:0];
    end
    irq_stat_next = irq_stat_next | {code_evt, rx_ovr_evt, tx_udr_evt};
    irq_next = |(irq_stat_reg & irq_mask_reg);
    rdata_next = 8'h00;
    if (bus_i.rd) begin
      if (bus_i.addr == `FHB_ADDR_RX_CODE) begin
        rdata_next = {rx_seen_reg, rx_seen_reg, rx_code_reg};
      end else if (bus_i.addr == `FHB_ADDR_RX_DATA) begin
        rdata_next = rx_mem[rx_rp_reg];
      end else if (bus_i.addr == `FHB_ADDR_TX_STAT) begin
        rdata_next = {5'h00, tx_empty, tx_full, tx_udr_reg};
      end else if (bus_i.addr == `FHB_ADDR_TX_CODE) begin
        rdata_next = tx_ctl_reg;
      end else if (bus_i.addr == `FHB_ADDR_RX_STAT) begin
        rdata_next = {5'h00, rx_ovr_reg, (rx_cnt_reg != `FHB_CNT_ZERO) ? rx_tag[rx_rp_reg] : 2'h0};
      end else if (bus_i.addr == `FHB_ADDR_IRQ_STAT) begin
        rdata_next = {5'h00, irq_stat_reg};
      end else if (bus_i.addr == `FHB_ADDR_IRQ_MASK) begin
        rdata_next = {5'h00, irq_mask_reg};
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  // transmit link: code send, abort on underrun, or fifo byte hand-off
  always_comb begin
    tx_st_next = tx_st_reg;
    bit_cnt_next = bit_cnt_reg;
    link_next = link_reg;
    tx_byte_next = tx_byte_reg;
    tx_bv_next = 1'b0;
    case (tx_st_reg)
      FHB_IDLE: begin
        if (tx_ctl_reg[`FHB_BIT_SEND] && !send_prev_reg) begin
          tx_st_next = FHB_CODE;
          bit_cnt_next = 3'h0;
        end else if (tx_udr_evt) begin
          tx_st_next = FHB_ABORT;
          bit_cnt_next = 3'h0;
        end else if (tx_pop) begin
          tx_byte_next = tx_mem[tx_rp_reg];
          tx_bv_next = 1'b1;
        end
      end
      FHB_CODE: begin
        if (tx_bit_req_i) begin
          link_next = tx_ctl_reg[bit_cnt_reg];
          bit_cnt_next = bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == `FHB_BIT_LAST) begin
            tx_st_next = FHB_IDLE;
          end
        end
      end
      FHB_ABORT: begin
        // abort is seven ones in a row
        if (tx_bit_req_i) begin
          link_next = 1'b1;
          bit_cnt_next = bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == `FHB_ABORT_LEN - 3'h1) begin
            tx_st_next = FHB_IDLE;
          end
        end
      end
      default: tx_st_next = FHB_IDLE;
    endcase
    if (!tx_ctl_reg[`FHB_BIT_SEL]) begin
      link_next = external_link_data_in_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rx_code_reg <= `FHB_RX_CODE_RST;
      rx_seen_reg <= 1'b0;
      tx_ctl_reg <= 8'h00;
      send_prev_reg <= 1'b0;
      tx_udr_reg <= 1'b0;
      rx_ovr_reg <= 1'b0;
      irq_stat_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
      rdata_reg <= 8'h00;
      irq_reg <= 1'b0;
      rx_wp_reg <= '0;
      rx_rp_reg <= '0;
      rx_cnt_reg <= '0;
      tx_wp_reg <= '0;
      tx_rp_reg <= '0;
      tx_cnt_reg <= '0;
      tx_st_reg <= FHB_IDLE;
      bit_cnt_reg <= 3'h0;
      link_reg <= 1'b1;
      tx_byte_reg <= 8'h00;
      tx_bv_reg <= 1'b0;
    end else begin
      rx_code_reg <= rx_code_next;
      rx_seen_reg <= rx_seen_next;
      tx_ctl_reg <= tx_ctl_next;
      send_prev_reg <= send_prev_next;
      tx_udr_reg <= tx_udr_next;
      rx_ovr_reg <= rx_ovr_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      rx_wp_reg <= rx_wp_next;
      rx_rp_reg <= rx_rp_next;
      rx_cnt_reg <= rx_cnt_next;
      tx_wp_reg <= tx_wp_next;
      tx_rp_reg <= tx_rp_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_st_reg <= tx_st_next;
      bit_cnt_reg <= bit_cnt_next;
      link_reg <= link_next;
      tx_byte_reg <= tx_byte_next;
      tx_bv_reg <= tx_bv_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign irq_o = irq_reg;
  assign link_out_o = link_reg;
  assign tx_byte_o = tx_byte_reg;
  assign tx_byte_valid_o = tx_bv_reg;

  sequence send_rise_s;
    tx_ctl_reg[`FHB_BIT_SEND] && !send_prev_reg && tx_st_reg == FHB_IDLE;
  endsequence
  sequence code_start_s;
    tx_st_reg == FHB_CODE && bit_cnt_reg == 3'h0;
  endsequence

  code_seen_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
    rx_seen_reg && !hit(bus_i, `FHB_ADDR_RX_CODE, 1'b0) |=> rx_seen_reg)
    else $error("code seen flag dropped without a read");
  code_seen_clr_a: assert property (@(posedge clk_i) disable iff (srst_i)
    hit(bus_i, `FHB_ADDR_RX_CODE, 1'b0) && !code_evt |=> !rx_seen_reg)
    else $error("code seen flag not cleared by read");
  code_reset_a: assert property (@(posedge clk_i)
    srst_i |=> rx_code_reg == `FHB_RX_CODE_RST)
    else $error("received code not all ones after reset");
  code_load_a: assert property (@(posedge clk_i) disable iff (srst_i)
    rx_code_valid_i |=> rx_code_reg == $past(rx_code_i))
    else $error("received code not loaded");
  rx_read_a: assert property (@(posedge clk_i) disable iff (srst_i)
    bus_i.rd && bus_i.addr == `FHB_ADDR_RX_DATA && rx_cnt_reg != `FHB_CNT_ZERO
    |=> rx_cnt_reg == $past(rx_cnt_reg) - 7'h01 + ($past(rx_push) ? 7'h01 : 7'h00))
    else $error("receive read did not advance the fifo");
  tx_flags_a: assert property (@(posedge clk_i) disable iff (srst_i)
    bus_i.rd && bus_i.addr == `FHB_ADDR_TX_STAT
    |=> rdata_o[`FHB_BIT_TX_EMPTY] == ($past(tx_cnt_reg) == `FHB_CNT_ZERO))
    else $error("transmit empty bit wrong");
  tx_full_a: assert property (@(posedge clk_i) disable iff (srst_i)
    bus_i.rd && bus_i.addr == `FHB_ADDR_TX_STAT
    |=> rdata_o[`FHB_BIT_TX_FULL] == ($past(tx_cnt_reg) == `FHB_CNT_FULL))
    else $error("transmit full bit wrong");
  udr_abort_a: assert property (@(posedge clk_i) disable iff (srst_i)
    tx_udr_evt && !(tx_ctl_reg[`FHB_BIT_SEND] && !send_prev_reg)
    |=> tx_st_reg == FHB_ABORT && tx_udr_reg)
    else $error("underrun did not start abort");
  udr_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
    tx_udr_reg && !hit(bus_i, `FHB_ADDR_TX_STAT, 1'b0) |=> tx_udr_reg)
    else $error("underrun flag dropped without a read");
  send_edge_a: assert property (@(posedge clk_i) disable iff (srst_i)
    send_rise_s |=> code_start_s)
    else $error("code send not started on rising send bit");
  ext_link_a: assert property (@(posedge clk_i) disable iff (srst_i)
    !tx_ctl_reg[`FHB_BIT_SEL] |=> link_out_o == $past(external_link_data_in_i))
    else $error("external link data not passed");
  tx_queue_a: assert property (@(posedge clk_i) disable iff (srst_i)
    tx_push && !tx_pop |=> tx_cnt_reg == $past(tx_cnt_reg) + 7'h01)
    else $error("transmit write not queued");
  ovr_set_a: assert property (@(posedge clk_i) disable iff (srst_i)
    rx_ovr_evt |=> rx_ovr_reg)
    else $error("receive overrun not latched");
endmodule

// file: tb/fhb_link_model.sv
// fhb_link_model: framing engine and link side of the packet and code port
// assumes the bench calls one task at a time, all on the rising clock edge
`timescale 1ns/1ps
module fhb_link_model (
  input wire logic clk_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic tx_byte_valid_i,
  input wire logic link_i,
  output logic code_valid_o,
  output logic [5:0] code_o,
  output logic byte_valid_o,
  output fhb_pkg::fhb_rx_byte_s byte_o,
  output logic bit_req_o,
  output logic in_pkt_o,
  output logic ext_o
);
  import fhb_pkg::*;
  logic [7:0] got[$];
  initial begin
    code_valid_o = 1'b0;
    code_o = 6'h00;
    byte_valid_o = 1'b0;
    byte_o = '0;
    bit_req_o = 1'b0;
    in_pkt_o = 1'b0;
    ext_o = 1'b1;
  end
  // mid-cycle capture, so the queue is settled before the bench looks at it
  always @(negedge clk_i) if (tx_byte_valid_i) got.push_back(tx_byte_i);
  task automatic code(input logic [5:0] c);
    @(posedge clk_i);
    code_valid_o <= 1'b1;
    code_o <= c;
    @(posedge clk_i);
    code_valid_o <= 1'b0;
    code_o <= ~c; // not held past the pulse
  endtask
  task automatic push(input logic [7:0] d, input logic f, input logic l);
    @(posedge clk_i);
    byte_valid_o <= 1'b1;
    byte_o <= '{data: d, first: f, last: l};
    @(posedge clk_i);
    byte_valid_o <= 1'b0;
    byte_o <= '{data: ~d, first: ~f, last: ~l};
  endtask
  // one bit slot; the bit is taken one edge after the request is seen
  task automatic req(output logic b);
    @(posedge clk_i);
    bit_req_o <= 1'b1;
    @(posedge clk_i);
    bit_req_o <= 1'b0;
    @(posedge clk_i);
    b = link_i;
  endtask
  task automatic set(input logic pkt, input logic ext);
    @(posedge clk_i);
    in_pkt_o <= pkt;
    ext_o <= ext;
  endtask
endmodule

// file: tb/fhb_port_tb_top.sv
// fhb_port_tb_top: self-checking bench for the packet and code port
// assumes fhb_link_model stands in for the framing engine and link
`timescale 1ns/1ps
`include "fhb_cfg.svh"
module fhb_port_tb_top;
  import fhb_pkg::*;
  localparam logic [7:0] RX_F = 8'h01 << `FHB_BIT_RX_FIRST;
  localparam logic [7:0] RX_L = 8'h01 << `FHB_BIT_RX_LAST;
  localparam logic [7:0] RX_O = 8'h01 << `FHB_BIT_RX_OVR;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  fhb_bus_s bus = '0;
  logic [7:0] rdata, tx_byte;
  logic irq, cv, bv, req, pkt, ext, tbv, link;
  logic [5:0] code;
  fhb_rx_byte_s rxb;
  int n_fail = 0;
  int checks_done = 0;
  always #12.5 clk_i = ~clk_i;
  fhb_port fhb_port_inst (.clk_i(clk_i), .srst_i(srst_i), .bus_i(bus), .rdata_o(rdata),
    .irq_o(irq), .rx_code_valid_i(cv), .rx_code_i(code), .rx_byte_valid_i(bv),
    .rx_byte_i(rxb), .tx_bit_req_i(req), .tx_in_packet_i(pkt), .tx_byte_o(tx_byte),
    .tx_byte_valid_o(tbv), .external_link_data_in_i(ext), .link_out_o(link));
  fhb_link_model fhb_link_model_inst (.clk_i(clk_i), .tx_byte_i(tx_byte),
    .tx_byte_valid_i(tbv), .link_i(link), .code_valid_o(cv), .code_o(code),
    .byte_valid_o(bv), .byte_o(rxb), .bit_req_o(req), .in_pkt_o(pkt), .ext_o(ext));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
    logic [7:0] v;
    @(posedge clk_i);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk_i);
    bus.rd <= 1'b0;
    @(posedge clk_i);
    v = rdata;
    if (a == `FHB_ADDR_TX_STAT) v = v & 8'h07;
    chk(n, e, v);
  endtask
  task automatic s_reset();
    rc(`FHB_ADDR_RX_CODE, 8'h3f, "rx_code");
    rc(`FHB_ADDR_TX_STAT, 8'h04, "tx_stat");
    rc(8'h20, 8'h00, "unmapped");
  endtask
  task automatic s_rx_code();
    fhb_link_model_inst.code(6'h15);
    wr(`FHB_ADDR_IRQ_MASK, 8'h04);
    repeat (2) @(posedge clk_i);
    chk("irq", 8'h01, {7'h00, irq});
    wr(`FHB_ADDR_IRQ_STAT, 8'h04);
    repeat (2) @(posedge clk_i);
    chk("irq", 8'h00, {7'h00, irq});
    rc(`FHB_ADDR_RX_CODE, 8'hd5, "rx_code");
    rc(`FHB_ADDR_RX_CODE, 8'h15, "rx_code");
  endtask
  task automatic s_rx_fifo();
    fhb_link_model_inst.push(8'ha5, 1'b1, 1'b0);
    fhb_link_model_inst.push(8'h3c, 1'b0, 1'b1);
    rc(`FHB_ADDR_RX_STAT, RX_F, "rx_stat");
    rc(`FHB_ADDR_RX_DATA, 8'ha5, "rx_data");
    rc(`FHB_ADDR_RX_STAT, RX_L, "rx_stat");
    rc(`FHB_ADDR_RX_DATA, 8'h3c, "rx_data");
  endtask
  // one byte beyond the depth must be lost and flagged
  task automatic s_overrun();
    for (int i = 0; i < 65; i++) fhb_link_model_inst.push(8'(i), 1'b0, 1'b0);
    rc(`FHB_ADDR_RX_STAT, RX_O, "rx_stat");
    rc(`FHB_ADDR_RX_STAT, 8'h00, "rx_stat");
    for (int i = 0; i < 64; i++) rc(`FHB_ADDR_RX_DATA, 8'(i), "rx_data");
  endtask
  task automatic s_link_sel();
    for (int v = 0; v < 2; v++) begin
      fhb_link_model_inst.set(1'b0, v[0]);
      repeat (2) @(posedge clk_i);
      chk("link", 8'(v), {7'h00, link});
    end
  endtask
  task automatic s_tx_fifo();
    logic b;
    wr(`FHB_ADDR_TX_CODE, 8'h40);
    for (int i = 0; i < 65; i++) begin
      if (i == 64) rc(`FHB_ADDR_TX_STAT, 8'h02, "tx_stat");
      else rc(`FHB_ADDR_TX_STAT, (i == 0) ? 8'h04 : 8'h00, "tx_stat");
      wr(`FHB_ADDR_TX_DATA, 8'(i * 3));
    end
    for (int i = 0; i < 64; i++) fhb_link_model_inst.req(b);
    chk("tx_count", 8'h40, 8'(fhb_link_model_inst.got.size()));
    for (int i = 0; i < 64; i++) chk("tx_byte", 8'(i * 3), fhb_link_model_inst.got[i]);
    rc(`FHB_ADDR_TX_STAT, 8'h04, "tx_stat");
  endtask
  task automatic s_code();
    logic b;
    logic [5:0] c;
    // bit 5 is zero, so the ones of a later abort differ from the last code bit
    c = 6'h0d;
    wr(`FHB_ADDR_TX_CODE, {2'b01, c});
    wr(`FHB_ADDR_TX_CODE, {2'b11, c});
    @(posedge clk_i);
    for (int i = 0; i < 6; i++) begin
      fhb_link_model_inst.req(b);
      chk("code_bit", {7'h00, c[i]}, {7'h00, b});
    end
  endtask
  task automatic s_underrun();
    logic b;
    wr(`FHB_ADDR_IRQ_MASK, 8'h01);
    fhb_link_model_inst.set(1'b1, 1'b0);
    fhb_link_model_inst.req(b);
    for (int i = 0; i < 7; i++) begin
      fhb_link_model_inst.req(b);
      chk("abort_bit", 8'h01, {7'h00, b});
    end
    chk("irq", 8'h01, {7'h00, irq});
    rc(`FHB_ADDR_TX_STAT, 8'h05, "tx_stat");
    rc(`FHB_ADDR_TX_STAT, 8'h04, "tx_stat");
    fhb_link_model_inst.set(1'b0, 1'b0);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    s_reset();
    s_rx_code();
    s_rx_fifo();
    s_overrun();
    s_link_sel();
    s_tx_fifo();
    s_code();
    s_underrun();
    tally_and_finish();
  end
  // the whole run needs about 1000 cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    tally_and_finish();
  end
endmodule
